// ==== conv_clk_div.v ====
// Divide-by-1/2/4/8 clock-enable generator for the converter clock path
`timescale 1ns/1ps

module conv_clk_div #(
    parameter CNT_W = 3
) (
    input  wire       mclk_i,       // System clock
    input  wire       rst_i,        // Synchronous reset, active high
    input  wire       invert_i,     // Invert the divided output, except in divide by one
    input  wire [1:0] div_sel_i,    // 00 /1, 01 /2, 10 /4, 11 /8
    output reg        clk_o,        // Divided clock level
    output reg        tick_o        // One pulse per divided period
);

    reg  [CNT_W-1:0] cnt_reg;
    wire [CNT_W-1:0] cnt_next;
    reg  [CNT_W-1:0] last_cnt;
    reg              phase;

    always @* begin
        case (div_sel_i)
            2'b00:   last_cnt = 3'h0;
            2'b01:   last_cnt = 3'h1;
            2'b10:   last_cnt = 3'h3;
            default: last_cnt = 3'h7;
        endcase
    end

    assign cnt_next = (cnt_reg >= last_cnt) ? {CNT_W{1'b0}} : cnt_reg + 3'h1;

    // High for the first half of the divided period; divide by one toggles each edge
    always @* begin
        if (div_sel_i == 2'b00) begin
            phase = ~clk_o ^ invert_i;
        end else begin
            phase = (cnt_next <= (last_cnt >> 1)) ^ invert_i;
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_reg <= {CNT_W{1'b0}};
            clk_o   <= 1'b0;
            tick_o  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            clk_o   <= (div_sel_i == 2'b00) ? ~clk_o : phase;
            tick_o  <= (cnt_next == {CNT_W{1'b0}});
        end
    end

endmodule

// ==== dcdc_converter_ctrl_regs.v ====
// Converter control and configuration register bank with clock-path and ADC sync selection
`timescale 1ns/1ps
`include "dcdc_ctrl_regs.vh"

// What this block does
// - Pulse-width code picks none, 20, 40, 80 ns
// - Switch bit: clear large, set small switches
// - Sync bit aligns ADC tracking and SAR clock
// - Voltage code maps 1.8 to 3.3 volts
// - Low-bias bit enables reduced-bias, lower current limit
// - Divider field divides system clock 1/2/4/8
// - Divider ignored when local oscillator selected
// - Source bit: clear oscillator, set system clock
// - Invert bit inverts divider output, except divide-by-one
// - SAR clock inverted when invert bit zero
module dcdc_converter_ctrl_regs (
    input  wire       mclk_i,               // System clock, 125 MHz
    input  wire       rst_i,                // Synchronous reset, active high
    input  wire [7:0] sfr_addr_i,           // Special-function register address
    input  wire [7:0] sfr_wdata_i,          // Write data
    input  wire       sfr_wr_i,             // Write strobe
    input  wire       sfr_rd_i,             // Read strobe
    output reg  [7:0] sfr_rdata_o,          // Read data, registered
    input  wire       local_osc_clk_i,      // Converter local oscillator level
    output reg  [1:0] min_pulse_sel_o,      // Minimum pulse width code
    output reg  [3:0] min_pulse_cycles_o,   // Minimum pulse width in system clocks
    output reg        switch_size_sel_o,    // 1 small switches, 0 large
    output reg  [2:0] out_voltage_sel_o,    // Target voltage code
    output reg  [7:0] out_voltage_onehot_o, // One-hot voltage selection to converter
    output reg        low_bias_en_o,        // Reduced-bias mode
    output reg        peak_limit_low_o,     // Lower peak inductor current limit
    output reg        peak_limit_sel_o,     // Peak current threshold bit
    output reg        sleep_float_o,        // Output floats in sleep
    output reg        conv_clk_o,           // Converter clock
    output reg        adc_sync_en_o,        // Tracking aligned to quiet interval
    output reg        sar_clk_o,            // SAR clock derived from converter clock
    output reg        sar_clk_aligned_o     // SAR clock is aligned to switching cycle
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [7:0] converter_control_reg;
    reg  [7:0] converter_configuration_reg;
    wire       div_clk;
    reg        local_osc_reg;
    reg        conv_clk_next;
    reg  [3:0] pulse_cycles_next;
    reg  [7:0] vout_onehot_next;
    reg        sar_clk_next;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            converter_control_reg       <= `CONV_CTL_RESET;
            converter_configuration_reg <= `CONV_CFG_RESET;
        end else if (sfr_wr_i) begin
            if (sfr_addr_i == `CONV_CTL_ADDR) begin
                converter_control_reg <= sfr_wdata_i;
            end else if (sfr_addr_i == `CONV_CFG_ADDR) begin
                converter_configuration_reg <= sfr_wdata_i;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            if (sfr_addr_i == `CONV_CTL_ADDR) begin
                sfr_rdata_o <= converter_control_reg;
            end else if (sfr_addr_i == `CONV_CFG_ADDR) begin
                sfr_rdata_o <= converter_configuration_reg;
            end else begin
                sfr_rdata_o <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Converter clock path

    conv_clk_div #(
        .CNT_W (3)
    ) u_div (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .invert_i  (converter_configuration_reg[`CFG_SYSCLK_INV_BIT]),
        .div_sel_i (converter_configuration_reg[`CFG_DIV_HI:`CFG_DIV_LO]),
        .clk_o     (div_clk),
        .tick_o    ()
    );

    always @* begin
        if (converter_configuration_reg[`CFG_CLKSRC_BIT]) begin
            conv_clk_next = div_clk;
        end else begin
            conv_clk_next = local_osc_reg;
        end
    end

    // Both sources pass one flop before the mux, so a source switch keeps the latency
    always @(posedge mclk_i) begin
        if (rst_i) begin
            local_osc_reg <= 1'b0;
            conv_clk_o    <= 1'b0;
        end else begin
            local_osc_reg <= local_osc_clk_i;
            conv_clk_o    <= conv_clk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Switching stage controls

    always @* begin
        case (converter_control_reg[`CTL_PULSE_HI:`CTL_PULSE_LO])
            2'b00:   pulse_cycles_next = 4'h0;
            2'b01:   pulse_cycles_next = `PULSE_20_CYC;
            2'b10:   pulse_cycles_next = `PULSE_40_CYC;
            default: pulse_cycles_next = `PULSE_80_CYC;
        endcase
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            min_pulse_sel_o    <= 2'h0;
            min_pulse_cycles_o <= 4'h0;
        end else begin
            min_pulse_sel_o    <= converter_control_reg[`CTL_PULSE_HI:`CTL_PULSE_LO];
            min_pulse_cycles_o <= pulse_cycles_next;
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            switch_size_sel_o <= 1'b1;
        end else begin
            switch_size_sel_o <= converter_control_reg[`CTL_SWITCH_BIT];
        end
    end

    always @* begin
        case (converter_control_reg[`CTL_VOUT_HI:`CTL_VOUT_LO])
            3'h0:    vout_onehot_next = 8'h01; // 1.8 V
            3'h1:    vout_onehot_next = 8'h02; // 1.9 V
            3'h2:    vout_onehot_next = 8'h04; // 2.0 V
            3'h3:    vout_onehot_next = 8'h08; // 2.1 V
            3'h4:    vout_onehot_next = 8'h10; // 2.4 V
            3'h5:    vout_onehot_next = 8'h20; // 2.7 V
            3'h6:    vout_onehot_next = 8'h40; // 3.0 V
            default: vout_onehot_next = 8'h80; // 3.3 V
        endcase
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            out_voltage_sel_o    <= 3'h1;
            out_voltage_onehot_o <= 8'h02;
        end else begin
            out_voltage_sel_o    <= converter_control_reg[`CTL_VOUT_HI:`CTL_VOUT_LO];
            out_voltage_onehot_o <= vout_onehot_next;
        end
    end

    always @(posedge mclk_i) begin
        if (rst_i) begin
            low_bias_en_o    <= 1'b0;
            peak_limit_low_o <= 1'b0;
        end else begin
            low_bias_en_o    <= converter_configuration_reg[`CFG_LOWBIAS_BIT];
            peak_limit_low_o <= converter_configuration_reg[`CFG_LOWBIAS_BIT];
        end
    end

    // Peak threshold and sleep connection are plain copies of their bits
    always @(posedge mclk_i) begin
        if (rst_i) begin
            peak_limit_sel_o <= 1'b0;
            sleep_float_o    <= 1'b0;
        end else begin
            peak_limit_sel_o <= converter_configuration_reg[`CFG_ILIMIT_BIT];
            sleep_float_o    <= converter_configuration_reg[`CFG_SLEEPFLT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ADC timing

    always @(posedge mclk_i) begin
        if (rst_i) begin
            adc_sync_en_o     <= 1'b0;
            sar_clk_aligned_o <= 1'b0;
        end else begin
            adc_sync_en_o     <= converter_control_reg[`CTL_SYNC_BIT];
            sar_clk_aligned_o <= converter_control_reg[`CTL_SYNC_BIT];
        end
    end

    always @* begin
        if (converter_control_reg[`CTL_SYNC_BIT]) begin
            sar_clk_next = conv_clk_next ^ ~converter_configuration_reg[`CFG_SARINV_BIT];
        end else begin
            sar_clk_next = 1'b0;
        end
    end

    // SAR clock held low while sync is off
    always @(posedge mclk_i) begin
        if (rst_i) begin
            sar_clk_o <= 1'b0;
        end else begin
            sar_clk_o <= sar_clk_next;
        end
    end

endmodule

// ==== dcdc_ctrl_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the converter control bank
`ifndef DCDC_CTRL_REGS_VH
`define DCDC_CTRL_REGS_VH

`define CONV_CFG_ADDR        8'h96
`define CONV_CTL_ADDR        8'h97
`define CONV_CFG_RESET       8'h00
`define CONV_CTL_RESET       8'h21

`define CTL_PULSE_HI         7
`define CTL_PULSE_LO         6
`define CTL_SWITCH_BIT       5
`define CTL_RSVD_BIT         4
`define CTL_SYNC_BIT         3
`define CTL_VOUT_HI          2
`define CTL_VOUT_LO          0

`define CFG_LOWBIAS_BIT      7
`define CFG_DIV_HI           6
`define CFG_DIV_LO           5
`define CFG_SARINV_BIT       4
`define CFG_SYSCLK_INV_BIT   3
`define CFG_ILIMIT_BIT       2
`define CFG_SLEEPFLT_BIT     1
`define CFG_CLKSRC_BIT       0

// Minimum pulse widths of 20, 40 and 80 ns in whole 8 ns system clocks, rounded up
`define PULSE_20_CYC         4'h3
`define PULSE_40_CYC         4'h5
`define PULSE_80_CYC         4'ha

`endif

// ==== dcdc_regs_chk.sv ====
// Port assertions for the converter register bank
`timescale 1ns/1ps
module dcdc_regs_chk (
    input wire       mclk_i,
    input wire       rst_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_wdata_i,
    input wire       sfr_wr_i,
    input wire       sfr_rd_i,
    input wire [7:0] sfr_rdata_o,
    input wire [1:0] min_pulse_sel_o,
    input wire [3:0] min_pulse_cycles_o,
    input wire       switch_size_sel_o,
    input wire [2:0] out_voltage_sel_o,
    input wire [7:0] out_voltage_onehot_o,
    input wire       low_bias_en_o,
    input wire       peak_limit_low_o,
    input wire       adc_sync_en_o,
    input wire       sar_clk_o,
    input wire       sar_clk_aligned_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_pulse_width_map: assert property (min_pulse_cycles_o == (min_pulse_sel_o == 2'h0 ? 4'h0 :
        min_pulse_sel_o == 2'h1 ? 4'h3 : min_pulse_sel_o == 2'h2 ? 4'h5 : 4'ha)) else $error("pulse cycles");
    a_voltage_onehot: assert property (out_voltage_onehot_o == (8'h01 << out_voltage_sel_o))
        else $error("onehot");
    a_voltage_write: assert property (sfr_wr_i && sfr_addr_i == 8'h97 |-> ##2
        out_voltage_sel_o == $past(sfr_wdata_i[2:0], 2)) else $error("out_voltage_sel write");
    a_low_bias_pair: assert property (low_bias_en_o == peak_limit_low_o) else $error("low bias");
    a_sync_pair: assert property (adc_sync_en_o == sar_clk_aligned_o) else $error("sync pair");
    a_sar_idle: assert property (!adc_sync_en_o |-> !sar_clk_o) else $error("sar idle");
    a_unmapped_read: assert property (sfr_rd_i && sfr_addr_i[7:1] != 7'h4b |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read");
    a_reset_values: assert property ($fell(rst_i) |-> out_voltage_onehot_o == 8'h02 && switch_size_sel_o
        && !low_bias_en_o) else $error("reset values");
endmodule

bind dcdc_converter_ctrl_regs dcdc_regs_chk chk_i (.*);

// ==== local_osc_model.sv ====
// Free-running local oscillator of the converter analog stage
`timescale 1ns/1ps
module local_osc_model #(
    parameter HALF = 5
) (
    input  wire mclk_i,          // System clock
    output reg  local_osc_clk_o  // Oscillator level
);
    integer cnt = 0;
    initial local_osc_clk_o = 1'b0;
    always @(posedge mclk_i) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
            local_osc_clk_o <= ~local_osc_clk_o;
    end
endmodule

// ==== tb.sv ====
// Self-checking testbench for the converter register bank
`timescale 1ns/1ps
module tb;
    reg        mclk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
    reg  [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, d, c;
    wire [7:0] sfr_rdata_o, out_voltage_onehot_o;
    wire [3:0] min_pulse_cycles_o;
    wire [2:0] out_voltage_sel_o;
    wire [1:0] min_pulse_sel_o;
    wire       osc, switch_size_sel_o, low_bias_en_o, peak_limit_low_o, conv_clk_o, adc_sync_en_o, sar_clk_o, aln;
    wire       pls, slp;
    integer    n_fail = 0, n_tests = 0, cyc = 0, i, k, t;
    dcdc_converter_ctrl_regs uut (.mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
        .local_osc_clk_i(osc), .min_pulse_sel_o(min_pulse_sel_o), .min_pulse_cycles_o(min_pulse_cycles_o),
        .switch_size_sel_o(switch_size_sel_o), .out_voltage_sel_o(out_voltage_sel_o),
        .out_voltage_onehot_o(out_voltage_onehot_o), .low_bias_en_o(low_bias_en_o),
        .peak_limit_low_o(peak_limit_low_o), .peak_limit_sel_o(pls), .sleep_float_o(slp), .conv_clk_o(conv_clk_o),
        .adc_sync_en_o(adc_sync_en_o), .sar_clk_o(sar_clk_o), .sar_clk_aligned_o(aln));
    local_osc_model osc_i (.mclk_i(mclk_i), .local_osc_clk_o(osc));
    initial forever #4 mclk_i = ~mclk_i;
    function [3:0] pw_cyc(input [1:0] s);
        pw_cyc = (s == 2'h0) ? 4'h0 : (s == 2'h1) ? 4'h3 : (s == 2'h2) ? 4'h5 : 4'ha;
    endfunction
    task end_sim;
        begin
            if (n_fail == 0 && n_tests > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [7:0] exp, input [7:0] got);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task acc(input [7:0] a, input [7:0] v, input w);
        begin
            @(posedge mclk_i);
            sfr_addr_i <= a;
            sfr_wdata_i <= v;
            sfr_wr_i <= w;
            sfr_rd_i <= !w;
            @(posedge mclk_i);
            sfr_wr_i <= 1'b0;
            sfr_rd_i <= 1'b0;
            repeat (2) @(posedge mclk_i);
            #1;
            if (!w)
                chk("rdata", v, sfr_rdata_o);
        end
    endtask
    task edges(input integer n);
        reg p;
        begin
            t = 0;
            k = 0;
            repeat (n) begin
                p = conv_clk_o;
                @(posedge mclk_i);
                #1;
                if (conv_clk_o !== p)
                    t = t + 1;
                if (sar_clk_o !== (conv_clk_o ^ ~c[4]))
                    k = k + 1;
            end
        end
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end
    initial begin
        void'($urandom(27));
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        chk("onehot", 8'h02, out_voltage_onehot_o);
        acc(8'h97, 8'h21, 1'b0);
        acc(8'h96, 8'h00, 1'b0);
        for (i = 0; i < 8; i = i + 1) begin
            d = $urandom & 8'hef;
            d[2:0] = i[2:0];
            d[7:6] = i[1:0];
            acc(8'h97, d, 1'b1);
            chk("out_voltage_sel", {5'h00, d[2:0]}, {5'h00, out_voltage_sel_o});
            chk("onehot", 8'h01 << i, out_voltage_onehot_o);
            chk("pulse", pw_cyc(d[7:6]), min_pulse_cycles_o);
            chk("pulsesel", {6'h00, d[7:6]}, {6'h00, min_pulse_sel_o});
            chk("switch", d[5], switch_size_sel_o);
            chk("sync", d[3], adc_sync_en_o);
            acc(8'h97, d, 1'b0);
        end
        for (i = 0; i < 8; i = i + 1) begin
            c = $urandom;
            c[6:5] = i[1:0];
            c[0] = i < 4;
            acc(8'h96, c, 1'b1);
            // control rewritten with only the sync bit, set from i[0], all other fields zero
            acc(8'h97, {4'h0, i[0], 3'h0}, 1'b1);
            chk("lowbias", c[7], low_bias_en_o);
            chk("ilimit", c[2], pls);
            chk("sleep", c[1], slp);
            acc(8'h96, c, 1'b0);
            edges(40);
            edges(80);
            chk("edges", c[0] ? (c[6:5] == 2'h3 ? 20 : c[6:5] == 2'h2 ? 40 : 80) : 16, t);
            if (i[0])
                chk("sarpol", 8'h00, k);
        end
        acc(8'h95, 8'hff, 1'b1);
        acc(8'h95, 8'h00, 1'b0);
        acc(8'h96, 8'h41, 1'b1);
        acc(8'h96, 8'h41, 1'b0);
        d[0] = conv_clk_o;
        acc(8'h96, 8'h49, 1'b1);
        acc(8'h96, 8'h49, 1'b0);
        chk("sysclk_path_invert", {7'h00, ~d[0]}, {7'h00, conv_clk_o});
        @(posedge mclk_i) rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        acc(8'h97, 8'h21, 1'b0);
        acc(8'h96, 8'h00, 1'b0);
        end_sim;
    end
endmodule
